// *** fsp_defines.vh ***
// fsp_defines.vh: offsets, field positions, keys and codes for the flash sector protect block
// assumes a 32-bit ahb-lite bus and a flash array macro on the same clock
// Behaviour
// R1 - erase whole block or one sector, program bytes
// R2 - sector erase touches only the chosen sector
// R3 - sectors 0 and 1 are 4k, sector 0 at f000-ffff
// R4 - sector count follows total flash size
// R5 - application programming never alters sector 0
// R6 - tool and in-circuit modes may alter everything
// R7 - readout protection blocks every external read path
// R8 - removing protection erases all memory first
// R9 - key sequence guards program and erase starts
// R10 - tool enters in-circuit mode before programming
// R11 - tool alone drives reset during a session
// R12 - serial clock never low while reset low normally
// R13 - one serial clock and data line, taken from application
// R14 - control status register at 29h resets to 00h
// R15 - serial data line is both input and output
// R16 - address decode picks sector for protection checks
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH
// register indices (byte address is four times the index)
`define FSP_IDX_CTRL 8'h29
`define FSP_IDX_GUARD 8'h30
`define FSP_IDX_ADDR 8'h31
`define FSP_IDX_DATA 8'h32
`define FSP_IDX_OPTION 8'h33
`define FSP_IDX_MODE 8'h34
`define FSP_CTRL_RESET 8'h00
// control status fields
`define FSP_CMD_LSB 0
`define FSP_CMD_MSB 2
`define FSP_GO_BIT 3
`define FSP_DENY_BIT 4
`define FSP_BUSY_BIT 5
`define FSP_UNLOCK_BIT 6
// command codes
`define FSP_CMD_NONE 3'h0
`define FSP_CMD_PROG 3'h1
`define FSP_CMD_SECT 3'h2
`define FSP_CMD_BLOCK 3'h3
`define FSP_CMD_OPTION 3'h4
// guard keys
`define FSP_KEY1 8'h56
`define FSP_KEY2 8'hae
// sector boundaries
`define FSP_SECT0_BASE 16'hf000
`define FSP_SECT1_BASE 16'he000
`define FSP_SECT_KBYTES 4
// erase masks, one bit per sector
`define FSP_MASK_S0 3'h1
`define FSP_MASK_S1 3'h2
`define FSP_MASK_S2 3'h4
// serial link commands
`define FSP_LINK_READ 8'ha1
// cycles after reset release before the mode strap is caught
`define FSP_STRAP_DELAY 4'h4
`endif

// *** fsp_sync2.v ***
// fsp_sync2.v: two flip-flop synchroniser for levels from pins
// assumes nothing but the local clock and reset
`default_nettype none
module fsp_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // level in and out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= INIT;
      q <= INIT;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // fsp_sync2
`default_nettype wire

// *** fsp_serial_link.v ***
// fsp_serial_link.v: byte shifter for the in-circuit serial clock and data lines
// assumes both pins already pass through fsp_sync2; msb first, sample on rising
// serial clock edge, drive the next bit after the falling edge
`default_nettype none
module fsp_serial_link (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // synchronised pins
  input wire sclk_s,
  input wire sdata_s,
  input wire enable,
  // byte interface
  input wire [7:0] tx_byte,
  input wire tx_load,
  output reg [7:0] rx_byte_ff,
  output reg rx_valid_ff,
  output reg sdata_out_ff,
  output reg sdata_oe_ff
);
  reg sclk_d_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] rx_sh_ff;
  reg [7:0] tx_sh_ff;
  reg tx_act_ff;
  wire rise = sclk_s & ~sclk_d_ff;
  wire fall = ~sclk_s & sclk_d_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_d_ff <= 1'b1;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      tx_act_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      sdata_out_ff <= 1'b1;
      sdata_oe_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      rx_valid_ff <= 1'b0;
      if (!enable) begin
        bit_cnt_ff <= 3'h0;
        tx_act_ff <= 1'b0;
        sdata_oe_ff <= 1'b0;
      end else begin
        if (tx_load) begin
          tx_sh_ff <= tx_byte;
          tx_act_ff <= 1'b1;
        end
        if (rise) begin
          rx_sh_ff <= {rx_sh_ff[6:0], sdata_s};
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == 3'h7) begin
            rx_byte_ff <= {rx_sh_ff[6:0], sdata_s};
            rx_valid_ff <= 1'b1;
          end
        end
        // data line turns round: driven only while a reply byte shifts out
        // the counter is zero on the first fall and on the ninth; only the ninth ends it
        if (fall && tx_act_ff && sdata_oe_ff && bit_cnt_ff == 3'h0) begin
          tx_act_ff <= 1'b0;
          sdata_oe_ff <= 1'b0;
        end else if (fall && tx_act_ff) begin
          sdata_out_ff <= tx_sh_ff[7]; // see R15
          sdata_oe_ff <= 1'b1; // see R15
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
      end
    end
  end
endmodule // fsp_serial_link
`default_nettype wire

// *** fsp_ctrl.v ***
// fsp_ctrl.v: flash access and sector protection controller, ahb-lite slave
// assumes a flash array macro on hclk that finishes each program or erase
// with a one-cycle fl_done and reads combinationally through fl_rdata
`default_nettype none
`include "fsp_defines.vh"
module fsp_ctrl #(
  parameter FLASH_KBYTES = 32
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // mode pins
  input wire tool_socket,
  input wire opt_rdp_stored,
  // in-circuit serial link pins
  input wire incircuit_serial_clock,
  input wire incircuit_serial_data_in,
  output reg incircuit_serial_data_out,
  output reg incircuit_serial_data_oe,
  output reg app_pins_released,
  // flash array macro
  output reg [15:0] fl_addr,
  output reg [7:0] fl_wdata,
  output reg fl_prog,
  output reg fl_erase,
  output reg [2:0] fl_erase_mask,
  output reg fl_opt_wr,
  output reg fl_opt_val,
  input wire fl_done,
  input wire [7:0] fl_rdata
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PROG = 3'h1;
  localparam [2:0] ST_ERASE = 3'h2;
  localparam [2:0] ST_OPTION = 3'h3;
  localparam [2:0] ST_RDP_ERASE = 3'h4;
  localparam [16:0] FLASH_BYTES = FLASH_KBYTES * 1024;
  localparam [16:0] FLASH_BASE = 17'h10000 - FLASH_BYTES;
  localparam [16:0] SECT_BYTES = `FSP_SECT_KBYTES * 1024;
  localparam [1:0] LK_IDLE = 2'h0;
  localparam [1:0] LK_ADDR_HI = 2'h1;
  localparam [1:0] LK_ADDR_LO = 2'h2;
  localparam [1:0] LK_REPLY = 2'h3;

  // sector decode, 3 means not a flash address of this part
  function [1:0] sector_of;
    input [15:0] a;
    begin
      if ({1'b0, a} < FLASH_BASE) begin
        sector_of = 2'h3;
      end else if (a >= `FSP_SECT0_BASE) begin
        sector_of = 2'h0; // see R3 see R16
      end else if (a >= `FSP_SECT1_BASE) begin
        sector_of = 2'h1; // see R16
      end else begin
        sector_of = 2'h2; // see R16
      end
    end
  endfunction

  // mask of sectors present for this flash size
  function [2:0] present_mask;
    input [16:0] bytes;
    begin
      if (bytes > 2 * SECT_BYTES) begin
        present_mask = `FSP_MASK_S0 | `FSP_MASK_S1 | `FSP_MASK_S2; // see R4
      end else if (bytes > SECT_BYTES) begin
        present_mask = `FSP_MASK_S0 | `FSP_MASK_S1; // see R4
      end else begin
        present_mask = `FSP_MASK_S0; // see R4
      end
    end
  endfunction

  function [2:0] mask_of;
    input [1:0] s;
    begin
      case (s)
        2'h0: mask_of = `FSP_MASK_S0;
        2'h1: mask_of = `FSP_MASK_S1;
        2'h2: mask_of = `FSP_MASK_S2;
        default: mask_of = 3'h0;
      endcase
    end
  endfunction

  // pin synchronisers
  wire sclk_s;
  wire sdata_s;
  wire tool_s;
  fsp_sync2 #(.W(3), .INIT(3'b110)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({incircuit_serial_clock, incircuit_serial_data_in, tool_socket}),
    .q({sclk_s, sdata_s, tool_s})
  );

  // state
  reg [7:0] ctrl_ff;
  reg [7:0] addr_hi_ff;
  reg [7:0] addr_lo_ff;
  reg [7:0] data_ff;
  reg [1:0] guard_ff;
  reg rdp_ff;
  reg rdp_target_ff;
  reg icc_mode_ff;
  reg strap_done_ff;
  reg [3:0] strap_cnt_ff;
  reg [2:0] st_ff;
  reg [2:0] nxt_st;
  reg wr_pend_ff;
  reg [7:0] wr_idx_ff;
  reg [1:0] lk_st_ff;
  reg [7:0] lk_hi_ff;
  reg lk_tx_load_ff;
  reg [7:0] lk_tx_ff;

  wire iap_mode = ~icc_mode_ff & ~tool_s;
  wire [15:0] prog_addr = {addr_hi_ff, addr_lo_ff};
  wire [1:0] prog_sect = sector_of(prog_addr);
  wire [2:0] avail = present_mask(FLASH_BYTES);

  // ahb address phase
  wire ahb_req = hsel & hready & htrans[1];
  wire [7:0] req_idx = haddr[9:2];
  wire [7:0] wr_byte = hwdata[7:0];
  wire wr_now = wr_pend_ff;
  wire ctrl_wr = wr_now & (wr_idx_ff == `FSP_IDX_CTRL);
  wire guard_wr = wr_now & (wr_idx_ff == `FSP_IDX_GUARD);
  wire go_req = ctrl_wr & wr_byte[`FSP_GO_BIT] & (guard_ff == 2'h2) & (st_ff == ST_IDLE);
  wire [2:0] go_cmd = wr_byte[`FSP_CMD_MSB:`FSP_CMD_LSB];

  // permission check for a start request
  reg allowed;
  always @* begin
    allowed = 1'b0;
    case (go_cmd)
      `FSP_CMD_PROG, `FSP_CMD_SECT: begin
        // sector 0 holds the boot loader, so it must survive a failed update
        allowed = (prog_sect != 2'h3) && ((mask_of(prog_sect) & avail) != 3'h0) &&
                  !(iap_mode && prog_sect == 2'h0); // see R5 see R6
      end
      `FSP_CMD_BLOCK, `FSP_CMD_OPTION: begin
        allowed = ~iap_mode; // see R5 see R6
      end
      default: allowed = 1'b0;
    endcase
  end

  // read mux
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (req_idx)
      `FSP_IDX_CTRL: begin
        rd_byte = ctrl_ff;
        rd_byte[`FSP_BUSY_BIT] = (st_ff != ST_IDLE);
        rd_byte[`FSP_UNLOCK_BIT] = (guard_ff == 2'h2);
      end
      `FSP_IDX_ADDR: rd_byte = addr_lo_ff;
      `FSP_IDX_DATA: rd_byte = data_ff;
      `FSP_IDX_OPTION: rd_byte = {7'h00, rdp_ff};
      `FSP_IDX_MODE: rd_byte = {5'h00, tool_s, icc_mode_ff, iap_mode};
      `FSP_IDX_GUARD: rd_byte = {6'h00, guard_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  // ahb slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= ahb_req & hwrite;
      if (ahb_req) begin
        wr_idx_ff <= req_idx;
        if (!hwrite) begin
          hrdata <= {24'h000000, rd_byte};
        end
      end
    end
  end

  // mode strap: serial clock held low through reset selects in-circuit mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt_ff <= 4'h0;
      strap_done_ff <= 1'b0;
      icc_mode_ff <= 1'b0;
      app_pins_released <= 1'b0;
    end else begin
      if (!strap_done_ff) begin
        strap_cnt_ff <= strap_cnt_ff + 4'h1;
        if (strap_cnt_ff == `FSP_STRAP_DELAY) begin
          strap_done_ff <= 1'b1;
          icc_mode_ff <= ~sclk_s; // see R10 see R12
        end
      end
      app_pins_released <= icc_mode_ff | tool_s; // see R13
    end
  end

  // registers, guard and start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `FSP_CTRL_RESET; // see R14
      addr_hi_ff <= 8'h00;
      addr_lo_ff <= 8'h00;
      data_ff <= 8'h00;
      guard_ff <= 2'h0;
    end else begin
      if (wr_now && wr_idx_ff == `FSP_IDX_ADDR) begin
        addr_hi_ff <= hwdata[15:8];
        addr_lo_ff <= wr_byte;
      end
      if (wr_now && wr_idx_ff == `FSP_IDX_DATA) begin
        data_ff <= wr_byte;
      end
      // two keys in a row unlock one start; any other guard write, or any control write with go set, relocks
      if (guard_wr) begin
        if (guard_ff == 2'h0 && wr_byte == `FSP_KEY1) begin
          guard_ff <= 2'h1; // see R9
        end else if (guard_ff == 2'h1 && wr_byte == `FSP_KEY2) begin
          guard_ff <= 2'h2; // see R9
        end else begin
          guard_ff <= 2'h0; // see R9
        end
      end else if (ctrl_wr && wr_byte[`FSP_GO_BIT]) begin
        guard_ff <= 2'h0; // see R9
      end
      if (ctrl_wr) begin
        ctrl_ff[`FSP_CMD_MSB:`FSP_CMD_LSB] <= go_cmd; // see R14
        ctrl_ff[7] <= wr_byte[7];
        if (wr_byte[`FSP_DENY_BIT]) begin
          ctrl_ff[`FSP_DENY_BIT] <= 1'b0;
        end
      end
      // a refused start sets the deny flag; set wins over a clear
      if (ctrl_wr && wr_byte[`FSP_GO_BIT] && !(go_req && allowed)) begin
        ctrl_ff[`FSP_DENY_BIT] <= 1'b1; // see R5 see R9
      end
    end
  end

  // operation sequencer
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (go_req && allowed) begin
          case (go_cmd)
            `FSP_CMD_PROG: nxt_st = ST_PROG;
            `FSP_CMD_SECT: nxt_st = ST_ERASE;
            `FSP_CMD_BLOCK: nxt_st = ST_ERASE;
            `FSP_CMD_OPTION: nxt_st = (rdp_ff && !data_ff[0]) ? ST_RDP_ERASE : ST_OPTION;
            default: nxt_st = ST_IDLE;
          endcase
        end
      end
      ST_PROG, ST_ERASE, ST_OPTION: nxt_st = fl_done ? ST_IDLE : st_ff;
      ST_RDP_ERASE: nxt_st = fl_done ? ST_OPTION : ST_RDP_ERASE; // see R8
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ST_IDLE;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_erase_mask <= 3'h0;
      fl_opt_wr <= 1'b0;
      fl_opt_val <= 1'b0;
      fl_wdata <= 8'h00;
      rdp_ff <= 1'b1;
      rdp_target_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_opt_wr <= 1'b0;
      // protection copy comes from the option byte once reset is over
      if (!strap_done_ff) begin
        rdp_ff <= opt_rdp_stored;
      end
      if (st_ff == ST_IDLE && nxt_st != ST_IDLE) begin
        fl_wdata <= data_ff;
        rdp_target_ff <= data_ff[0];
        case (go_cmd)
          `FSP_CMD_PROG: fl_prog <= 1'b1; // see R1
          `FSP_CMD_SECT: begin
            fl_erase <= 1'b1; // see R1
            fl_erase_mask <= mask_of(prog_sect); // see R2
          end
          `FSP_CMD_BLOCK: begin
            fl_erase <= 1'b1; // see R1
            fl_erase_mask <= avail; // see R1
          end
          default: begin
            // lifting protection wipes the array before the option changes
            if (nxt_st == ST_RDP_ERASE) begin
              fl_erase <= 1'b1; // see R8
              fl_erase_mask <= avail; // see R8
            end else begin
              fl_opt_wr <= 1'b1;
              fl_opt_val <= data_ff[0];
            end
          end
        endcase
      end
      if (st_ff == ST_RDP_ERASE && fl_done) begin
        fl_opt_wr <= 1'b1; // see R8
        fl_opt_val <= rdp_target_ff; // see R8
      end
      if (st_ff == ST_OPTION && fl_done) begin
        rdp_ff <= rdp_target_ff;
      end
    end
  end

  // serial link: read command with two address bytes, one reply byte
  wire [7:0] lk_rx;
  wire lk_rx_valid;
  wire lk_dout;
  wire lk_doe;
  fsp_serial_link u_link (
    .hclk(hclk),
    .hresetn(hresetn),
    .sclk_s(sclk_s),
    .sdata_s(sdata_s),
    .enable(icc_mode_ff), // see R13
    .tx_byte(lk_tx_ff),
    .tx_load(lk_tx_load_ff),
    .rx_byte_ff(lk_rx),
    .rx_valid_ff(lk_rx_valid),
    .sdata_out_ff(lk_dout),
    .sdata_oe_ff(lk_doe)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_st_ff <= LK_IDLE;
      lk_hi_ff <= 8'h00;
      lk_tx_ff <= 8'h00;
      lk_tx_load_ff <= 1'b0;
      fl_addr <= 16'h0000;
      incircuit_serial_data_out <= 1'b1;
      incircuit_serial_data_oe <= 1'b0;
    end else begin
      lk_tx_load_ff <= 1'b0;
      incircuit_serial_data_out <= lk_dout; // see R15
      incircuit_serial_data_oe <= lk_doe & icc_mode_ff; // see R13 see R15
      case (lk_st_ff)
        LK_IDLE: begin
          fl_addr <= prog_addr;
          if (lk_rx_valid && lk_rx == `FSP_LINK_READ) begin
            lk_st_ff <= LK_ADDR_HI;
          end
        end
        LK_ADDR_HI: begin
          if (lk_rx_valid) begin
            lk_hi_ff <= lk_rx;
            lk_st_ff <= LK_ADDR_LO;
          end
        end
        LK_ADDR_LO: begin
          if (lk_rx_valid) begin
            fl_addr <= {lk_hi_ff, lk_rx};
            lk_st_ff <= LK_REPLY;
          end
        end
        LK_REPLY: begin
          // a busy array or a protected part answers zero, never the content
          lk_tx_ff <= (rdp_ff || st_ff != ST_IDLE) ? 8'h00 : fl_rdata; // see R7
          lk_tx_load_ff <= 1'b1;
          lk_st_ff <= LK_IDLE;
        end
        default: lk_st_ff <= LK_IDLE;
      endcase
      if (!icc_mode_ff) begin
        lk_st_ff <= LK_IDLE;
      end
    end
  end
endmodule // fsp_ctrl
`default_nettype wire

// *** fsp_ctrl_chk.sv ***
// fsp_ctrl_chk.sv: port-level assertions for the flash sector protect controller
// assumes it is bound to fsp_ctrl and sees only that module's ports
`default_nettype none
module fsp_ctrl_chk #(
  parameter FLASH_KBYTES = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // mode and link
  input wire logic opt_rdp_stored,
  input wire logic incircuit_serial_data_oe,
  input wire logic app_pins_released,
  // flash array
  input wire logic [15:0] fl_addr,
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic [2:0] fl_erase_mask,
  input wire logic fl_opt_wr,
  input wire logic fl_opt_val
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] LOW_ADDR = 17'(65536 - FLASH_KBYTES * 1024);
  localparam logic [2:0] AVAIL = (FLASH_KBYTES > 8) ? 3'h7 : (FLASH_KBYTES > 4) ? 3'h3 : 3'h1;
  // remembers a full erase until the option write that must follow it
  logic full_erase_ff;
  logic nxt_full_erase;
  assign nxt_full_erase = fl_opt_wr ? 1'b0 : (fl_erase && fl_erase_mask == AVAIL) | full_erase_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_erase_ff <= 1'b0;
    end else begin
      full_erase_ff <= nxt_full_erase;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_prog_pulse: assert property (fl_prog |=> !fl_prog)
    else $error("program strobe longer than one cycle");
  chk_erase_pulse: assert property (fl_erase |=> !fl_erase)
    else $error("erase strobe longer than one cycle");
  chk_single_op: assert property (fl_prog |-> !fl_erase && !fl_opt_wr)
    else $error("two array operations at once");
  chk_app_sector0: assert property (fl_prog && !app_pins_released |-> fl_addr < 16'hf000)
    else $error("boot sector programmed in application mode");
  chk_app_erase: assert property (fl_erase && !app_pins_released |-> !fl_erase_mask[0])
    else $error("boot sector erased in application mode");
  chk_app_option: assert property (fl_opt_wr |-> app_pins_released)
    else $error("option written in application mode");
  chk_sector_avail: assert property (fl_erase |-> fl_erase_mask != 3'h0 && (fl_erase_mask & ~AVAIL) == 3'h0)
    else $error("erase of an absent sector");
  chk_prog_range: assert property (fl_prog |-> {1'b0, fl_addr} >= LOW_ADDR)
    else $error("program below flash base");
  chk_unprotect_erase: assert property (fl_opt_wr && !fl_opt_val && opt_rdp_stored |-> full_erase_ff)
    else $error("protection lifted without full erase");
  chk_link_oe: assert property (incircuit_serial_data_oe |-> app_pins_released)
    else $error("data line driven in application mode");
  cover property (fl_prog);
  cover property (fl_erase && fl_erase_mask == 3'h7);
  cover property (fl_opt_wr && !fl_opt_val);
  cover property ($rose(incircuit_serial_data_oe));
endmodule // fsp_ctrl_chk
bind fsp_ctrl fsp_ctrl_chk #(.FLASH_KBYTES(FLASH_KBYTES)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .opt_rdp_stored(opt_rdp_stored),
  .incircuit_serial_data_oe(incircuit_serial_data_oe), .app_pins_released(app_pins_released),
  .fl_addr(fl_addr), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_erase_mask(fl_erase_mask),
  .fl_opt_wr(fl_opt_wr), .fl_opt_val(fl_opt_val));
`default_nettype wire

// *** fsp_tool.sv ***
// fsp_tool.sv: behavioural programming tool on the in-circuit serial link
// assumes the device samples on rising serial clock and replies after falling edges
`default_nettype none
`include "fsp_defines.vh"
module fsp_tool (
  // link pins
  output var logic sclk,
  output wire logic sdata,
  input wire logic dut_out,
  input wire logic dut_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tool_d = 1'b1;
  logic tool_oe = 1'b0;
  // pulled-up line: released by both ends it reads high
  assign sdata = dut_oe ? dut_out : (tool_oe ? tool_d : 1'b1);
  initial sclk = 1'b1;
  // held low through reset release to enter in-circuit mode
  task automatic strap();
    sclk = 1'b0;
  endtask
  // clock stays low between frames so no stray rising edge starts a byte
  task automatic link_read(input logic [15:0] a, output logic [7:0] r, output logic oe_ok);
    logic [23:0] cmd;
    cmd = {`FSP_LINK_READ, a};
    oe_ok = 1'b1;
    #3;
    tool_oe = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      tool_d = cmd[i];
      #40;
      sclk = 1'b1;
      #40;
    end
    tool_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      #40;
      r[i] = sdata;
      oe_ok = oe_ok & dut_oe;
      sclk = 1'b1;
      #40;
    end
    sclk = 1'b0;
    #80;
    oe_ok = oe_ok & !dut_oe;
  endtask
endmodule // fsp_tool
`default_nettype wire

// *** tb_top.sv ***
// tb_top.sv: self-checking bench for the flash sector protect controller
// assumes fsp_ctrl with its bound checker and the fsp_tool link partner
`default_nettype none
`include "fsp_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic tool_socket = 1'b0;
  logic opt_rdp_stored = 1'b0;
  logic fl_done = 1'b0;
  logic [1:0] done_q = 2'h0;
  logic [15:0] last_a = 16'h0;
  logic [7:0] last_d = 8'h0;
  logic [2:0] last_m = 3'h0;
  logic erase_first = 1'b0;
  logic [7:0] b;
  logic ok;
  int n_ops = 0;
  int n_fail = 0;
  int n_compared = 0;
  // cmd, address, expected array strobes, expected erase mask
  logic [27:0] tab [14] = '{28'h1e01010, 28'h1f00000, 28'h17fff00, 28'h1800010,
    28'h2efff12, 28'h2e00012, 28'h2dfff14, 28'h2f80000, 28'h3800000, 28'h4800000,
    28'h1ffff10, 28'h3800017, 28'h2f00011, 28'h4800010};
  wire [31:0] hrdata;
  wire [15:0] fl_addr;
  wire [7:0] fl_wdata, fl_rdata;
  wire [2:0] fl_mask;
  wire hreadyout, hresp, sclk, sdata, sdout, sdoe, app_rel, fl_prog, fl_erase, fl_opt_wr, fl_opt_val;
  always #4 hclk = ~hclk;
  assign fl_rdata = fl_addr[7:0] ^ 8'h3c;
  fsp_ctrl #(.FLASH_KBYTES(32)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tool_socket(tool_socket), .opt_rdp_stored(opt_rdp_stored),
    .incircuit_serial_clock(sclk), .incircuit_serial_data_in(sdata),
    .incircuit_serial_data_out(sdout), .incircuit_serial_data_oe(sdoe),
    .app_pins_released(app_rel), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_prog(fl_prog),
    .fl_erase(fl_erase), .fl_erase_mask(fl_mask), .fl_opt_wr(fl_opt_wr),
    .fl_opt_val(fl_opt_val), .fl_done(fl_done), .fl_rdata(fl_rdata));
  fsp_tool u_tool (.sclk(sclk), .sdata(sdata), .dut_out(sdout), .dut_oe(sdoe));
  // array model: done three cycles after each strobe, stored option follows writes
  always @(posedge hclk) begin
    done_q <= {done_q[0], fl_prog | fl_erase | fl_opt_wr};
    fl_done <= done_q[1];
    if (fl_prog | fl_erase | fl_opt_wr) begin
      n_ops <= n_ops + 1;
    end
    if (fl_prog) begin
      last_a <= fl_addr;
      last_d <= fl_wdata;
    end
    if (fl_erase) begin
      last_m <= fl_mask;
    end
    if (fl_opt_wr) begin
      erase_first <= (last_m == 3'h7);
      opt_rdp_stored <= fl_opt_val;
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(nm, x, e);
  endtask
  task automatic op(input logic [2:0] cmd, input logic [15:0] a, input int exp_n,
    input logic [2:0] m);
    int n0;
    int k;
    logic [31:0] v;
    wr(`FSP_IDX_ADDR, {16'h0, a});
    wr(`FSP_IDX_DATA, {24'h0, a[7:0] ^ 8'ha5});
    wr(`FSP_IDX_GUARD, 32'h56);
    wr(`FSP_IDX_GUARD, 32'hae);
    rd("unlocked", `FSP_IDX_CTRL, 32'h40);
    n0 = n_ops;
    wr(`FSP_IDX_CTRL, {28'h0, 1'b1, cmd});
    v = 32'h20;
    k = 0;
    while (v[5] && k < 30) begin
      bus(1'b0, `FSP_IDX_CTRL, 32'h0, v);
      k++;
    end
    chk("busy end", {v[5], k == 30}, 2'b00);
    chk("strobes", n_ops - n0, exp_n);
    chk("deny", v[4], exp_n == 0);
    if (exp_n != 0 && cmd == 3'h1) begin
      chk("prog addr", last_a, a);
      chk("prog data", last_d, a[7:0] ^ 8'ha5);
    end
    if (exp_n != 0 && (cmd == 3'h2 || cmd == 3'h3)) begin
      chk("erase mask", last_m, m);
    end
    wr(`FSP_IDX_CTRL, 32'h10);
  endtask
  task automatic run(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      op(tab[i][26:24], tab[i][23:8], int'(tab[i][7:4]), tab[i][2:0]);
    end
  endtask
  task automatic link(input logic [15:0] a, input logic [7:0] e);
    u_tool.link_read(a, b, ok);
    @(posedge hclk);
    chk("reply", b, e);
    chk("oe frame", ok, 1'b1);
  endtask
  // the tool owns reset for the whole session
  task automatic do_reset(input logic strap, input logic rdp);
    hresetn <= 1'b0;
    opt_rdp_stored <= rdp;
    if (strap) begin
      u_tool.strap();
    end
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
  initial begin
    logic [31:0] v;
    do_reset(1'b0, 1'b0);
    rd("ctrl reset", `FSP_IDX_CTRL, 32'h0);
    rd("mode app", `FSP_IDX_MODE, 32'h1);
    wr(8'h40, 32'hff);
    rd("unmapped", 8'h40, 32'h0);
    chk("released", app_rel, 1'b0);
    wr(`FSP_IDX_CTRL, 32'h80);
    rd("ctrl rw", `FSP_IDX_CTRL, 32'h80);
    wr(`FSP_IDX_CTRL, 32'h09);
    bus(1'b0, `FSP_IDX_CTRL, 32'h0, v);
    chk("locked go", v[4], 1'b1);
    wr(`FSP_IDX_CTRL, 32'h10);
    rd("deny clear", `FSP_IDX_CTRL, 32'h0);
    run(0, 9);
    tool_socket <= 1'b1;
    repeat (6) @(posedge hclk);
    rd("mode tool", `FSP_IDX_MODE, 32'h4);
    chk("released", app_rel, 1'b1);
    run(10, 13);
    tool_socket <= 1'b0;
    do_reset(1'b1, 1'b1);
    rd("mode icc", `FSP_IDX_MODE, 32'h2);
    rd("option", `FSP_IDX_OPTION, 32'h1);
    chk("released", app_rel, 1'b1);
    link(16'he010, 8'h00);
    op(3'h4, 16'h8001, 2, 3'h0);
    chk("erase first", erase_first, 1'b1);
    chk("full mask", last_m, 3'h7);
    rd("option clear", `FSP_IDX_OPTION, 32'h0);
    link(16'he010, 8'h10 ^ 8'h3c);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
